/* verilog/mfe_consts.svh */
// Offsets, field positions, reset values and fixed figures of the feature-enable register.
`ifndef MFE_CONSTS_SVH
`define MFE_CONSTS_SVH
// ****************************************************************
// Register map (byte offsets on APB)
// ****************************************************************
`define MFE_OFF_LO        12'h000
`define MFE_OFF_HI        12'h004
`define MFE_OFF_STATUS    12'h008
// ****************************************************************
// Field positions within the 64-bit register
// ****************************************************************
`define MFE_BIT_LEAF_LIM  22
`define MFE_BIT_CTX_MODE  24
`define MFE_LIM_LEAF      8'h03
`define MFE_RST_LEAF_LIM  1'b0
`define MFE_RST_CTX_MODE  1'b0
`endif

/* verilog/mfe_pkg.sv */
// Types shared by the feature-enable register block.
package mfe_pkg;
    typedef enum logic
    {
        MFE_CTX_ADAPTIVE,
        MFE_CTX_SHARED
    } mfe_ctx_t;
endpackage

/* verilog/mfe_share_ctl.sv */
// Cache sharing decision between logical processors.
`timescale 1ns/1ns
`include "mfe_consts.svh"
module mfe_share_ctl
    import mfe_pkg::*;
#(
    parameter int PTB_W = 32
)
(
    input  wire logic             sys_clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             ctx_mode_i,
    input  wire logic             multi_lp_i,
    input  wire logic [PTB_W-1:0] ptb_lp0_i,
    input  wire logic [PTB_W-1:0] ptb_lp1_i,
    output logic                  share_o
);
    logic next_share;
    // ****************************************************************
    // Sharing decision
    // ****************************************************************
    // Without several logical processors the mode has no meaning.
    always_comb
    begin
        next_share = 1'b0;
        if (multi_lp_i)
        begin
            if (ctx_mode_i == MFE_CTX_SHARED)
                next_share = 1'b1;
            else
                next_share = (ptb_lp0_i == ptb_lp1_i);
        end
    end
    // Registered so the cache sees a clean level.
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            share_o <= 1'b0;
        else
            share_o <= next_share;
    end
    chk_adaptive_share: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (multi_lp_i && !ctx_mode_i) |=> share_o == $past(ptb_lp0_i == ptb_lp1_i))
        else $error("adaptive sharing wrong");
    chk_single_lp: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !multi_lp_i |=> !share_o)
        else $error("sharing without multiple logical processors");
    chk_shared_mode: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (multi_lp_i && ctx_mode_i) |=> share_o)
        else $error("shared mode not sharing");
    cov_adaptive_equal: cover property (@(posedge sys_clk_i)
        multi_lp_i && !ctx_mode_i && ptb_lp0_i == ptb_lp1_i);
endmodule

/* verilog/mfe_regs.sv */
// APB register block holding the upper feature-enable control bits.
`timescale 1ns/1ns
`include "mfe_consts.svh"
// Behaviour
// - Bit 22 read/write, caps identify leaf
// - Cap set: leaf zero reports three
// - Cap resets zero; clear reports true maximum
// - Bit 24: one shared, zero adaptive
// - Adaptive shares only on equal page bases
// - Mode matters only with multiple logical processors
module mfe_regs
    import mfe_pkg::*;
#(
    parameter int   PTB_W        = 32,
    parameter logic [7:0] TRUE_MAX_LEAF = 8'h05
)
(
    input  wire logic             sys_clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             psel_i,
    input  wire logic             penable_i,
    input  wire logic             pwrite_i,
    input  wire logic [11:0]      paddr_i,
    input  wire logic [31:0]      pwdata_i,
    input  wire logic [3:0]       pstrb_i,
    output logic                  pready_o,
    output logic [31:0]           prdata_o,
    output logic                  pslverr_o,
    input  wire logic             multi_lp_i,
    input  wire logic [PTB_W-1:0] ptb_lp0_i,
    input  wire logic [PTB_W-1:0] ptb_lp1_i,
    output logic [7:0]            max_basic_leaf_value_o,
    output logic                  ctx_shared_o,
    output logic                  share_o
);
    logic        leaf_lim;
    logic        ctx_mode;
    logic        acc;
    logic        hit;
    logic [31:0] next_rdata;
    logic [63:0] reg_view;
    // ****************************************************************
    // APB access decode
    // ****************************************************************
    // Zero wait states; every access finishes in its first access cycle.
    assign acc       = psel_i && penable_i;
    assign pready_o  = acc;
    assign hit       = (paddr_i == `MFE_OFF_LO) || (paddr_i == `MFE_OFF_HI)
                       || (paddr_i == `MFE_OFF_STATUS);
    assign pslverr_o = acc && !hit;
    // Only the defined bits exist; all others read zero.
    always_comb
    begin
        reg_view = 64'h0000000000000000;
        reg_view[`MFE_BIT_LEAF_LIM] = leaf_lim;
        reg_view[`MFE_BIT_CTX_MODE] = ctx_mode;
    end
    // ****************************************************************
    // Control bits
    // ****************************************************************
    // Byte lane 2 carries bit 22 and byte lane 3 carries bit 24; reserved bits have no storage.
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            leaf_lim <= `MFE_RST_LEAF_LIM;
            ctx_mode <= `MFE_RST_CTX_MODE;
        end
        else if (acc && pwrite_i && paddr_i == `MFE_OFF_LO)
        begin
            if (pstrb_i[2])
                leaf_lim <= pwdata_i[`MFE_BIT_LEAF_LIM];
            if (pstrb_i[3])
                ctx_mode <= pwdata_i[`MFE_BIT_CTX_MODE];
        end
    end
    // ****************************************************************
    // Read data
    // ****************************************************************
    // Status shows the reported leaf so software can check the cap.
    always_comb
    begin
        next_rdata = 32'h00000000;
        case (paddr_i)
            `MFE_OFF_LO:     next_rdata = reg_view[31:0];
            `MFE_OFF_HI:     next_rdata = reg_view[63:32];
            `MFE_OFF_STATUS: next_rdata = {24'h000000, max_basic_leaf_value_o};
            default:         next_rdata = 32'h00000000;
        endcase
    end
    // Read data is latched in setup so it is stable in access.
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            prdata_o <= 32'h00000000;
        else if (psel_i && !penable_i && !pwrite_i)
            prdata_o <= next_rdata;
    end
    // ****************************************************************
    // Identify leaf report
    // ****************************************************************
    // Software must only set the cap where the true maximum exceeds three.
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            max_basic_leaf_value_o <= TRUE_MAX_LEAF;
        else if (leaf_lim)
            max_basic_leaf_value_o <= `MFE_LIM_LEAF;
        else
            max_basic_leaf_value_o <= TRUE_MAX_LEAF;
    end
    assign ctx_shared_o = ctx_mode;
    // ****************************************************************
    // Cache context sharing
    // ****************************************************************
    mfe_share_ctl #(.PTB_W(PTB_W)) u_share
    (
        .sys_clk_i  (sys_clk_i),
        .sys_rst_i  (sys_rst_i),
        .ctx_mode_i (ctx_mode),
        .multi_lp_i (multi_lp_i),
        .ptb_lp0_i  (ptb_lp0_i),
        .ptb_lp1_i  (ptb_lp1_i),
        .share_o    (share_o)
    );
    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_leaf_capped: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        leaf_lim |=> max_basic_leaf_value_o == 8'h03)
        else $error("capped leaf not three");
    chk_leaf_true: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !leaf_lim |=> max_basic_leaf_value_o == TRUE_MAX_LEAF)
        else $error("uncapped leaf not true maximum");
    chk_leaf_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (acc && pwrite_i && paddr_i == 12'h000 && pstrb_i[2])
        |=> leaf_lim == $past(pwdata_i[22]))
        else $error("cap bit write lost");
    chk_ctx_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (acc && pwrite_i && paddr_i == 12'h000 && pstrb_i[3])
        |=> ctx_mode == $past(pwdata_i[24]))
        else $error("mode bit write lost");
    chk_reset_vals: assert property (@(posedge sys_clk_i)
        $past(sys_rst_i) |-> !leaf_lim && !ctx_mode)
        else $error("reset values wrong");
    chk_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (psel_i && !penable_i && !pwrite_i && paddr_i == 12'h004) |=> prdata_o == 32'h0)
        else $error("reserved high word not zero");
    chk_reserved_low: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (psel_i && !penable_i && !pwrite_i && paddr_i == 12'h000)
        |=> (prdata_o & 32'hFEBFFFFF) == 32'h0)
        else $error("reserved low bits not zero");
    chk_unmapped_err: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (acc && !hit) |-> pslverr_o && pready_o)
        else $error("unmapped access without error");
    cov_cap_set: cover property (@(posedge sys_clk_i) $rose(leaf_lim));
    cov_shared: cover property (@(posedge sys_clk_i) $rose(ctx_mode));
    cov_unmapped: cover property (@(posedge sys_clk_i) acc && !hit);
endmodule

/* sim/mfe_tb.sv */
// Self-checking bench for the feature-enable register block.
`timescale 1ns/1ns
`include "mfe_consts.svh"
module testbench;
    localparam logic [7:0] TML = 8'h07;
    logic        sys_clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic        multi_lp_i, ctx_shared_o, share_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, ptb_lp0_i, ptb_lp1_i, r;
    logic [3:0]  pstrb_i;
    logic [7:0]  leaf_o;
    logic [32:0] exp_v;
    logic [32:0] exp_q[$];
    int          error_cnt, checks_done, seed;
    mfe_regs #(.PTB_W(32), .TRUE_MAX_LEAF(TML)) dut_u (.sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o),
        .prdata_o(prdata_o), .pslverr_o(pslverr_o), .multi_lp_i(multi_lp_i),
        .ptb_lp0_i(ptb_lp0_i), .ptb_lp1_i(ptb_lp1_i), .max_basic_leaf_value_o(leaf_o),
        .ctx_shared_o(ctx_shared_o), .share_o(share_o));
    // ****************************************************************
    // Reporting
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ****************************************************************
    // APB master
    // ****************************************************************
    // Reads note {slverr, data} before the cycle; one idle edge after each
    // transfer keeps psel from being assigned twice in one time step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        n = 0;
        if (!w)
            exp_q.push_back(e);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        @(posedge sys_clk_i);
        while (pready_o !== 1'b1 && n < 50)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        if (n >= 50)
        begin
            error_cnt++;
            stop_test();
        end
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    // Watches completed reads and compares them with the oldest note.
    always @(posedge sys_clk_i)
    begin
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i)
        begin
            exp_v = exp_q.pop_front();
            chk("prdata", exp_v[31:0], prdata_o);
            chk("pslverr", {31'h0, exp_v[32]}, {31'h0, pslverr_o});
        end
    end
    initial
    begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    // A hung run is cut short and counted as a mismatch.
    initial
    begin
        repeat (5000) @(posedge sys_clk_i);
        error_cnt++;
        stop_test();
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        {psel_i, penable_i, pwrite_i, multi_lp_i} = 4'h0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        pstrb_i = 4'hF;
        ptb_lp0_i = 32'h0;
        ptb_lp1_i = 32'h0;
        sys_rst_i = 1'b1;
        seed = 92;
        error_cnt = 0;
        checks_done = 0;
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge sys_clk_i);
        chk("leaf", {24'h0, TML}, {24'h0, leaf_o});
        chk("ctx", 32'h0, {31'h0, ctx_shared_o});
        apb(1'b0, `MFE_OFF_LO, 32'h0, 33'h0);
        apb(1'b0, `MFE_OFF_STATUS, 32'h0, {25'h0, TML});
        apb(1'b1, `MFE_OFF_LO, 32'hFFFFFFFF, 33'h0);
        apb(1'b0, `MFE_OFF_LO, 32'h0, 33'h001400000);
        apb(1'b0, `MFE_OFF_STATUS, 32'h0, 33'h3);
        chk("leaf", 32'h3, {24'h0, leaf_o});
        chk("ctx", 32'h1, {31'h0, ctx_shared_o});
        apb(1'b1, `MFE_OFF_HI, $random(seed), 33'h0);
        apb(1'b0, `MFE_OFF_HI, 32'h0, 33'h0);
        apb(1'b0, 12'h00C, 32'h0, {1'b1, 32'h0});
        // Every mix of core kind, mode and equal or unequal page bases.
        for (int i = 0; i < 8; i++)
        begin
            r = $random(seed);
            apb(1'b1, `MFE_OFF_LO, {7'h0, i[1], 24'h0}, 33'h0);
            multi_lp_i <= i[2];
            ptb_lp0_i <= r;
            ptb_lp1_i <= i[0] ? r : ~r;
            repeat (2) @(posedge sys_clk_i);
            chk("share", {31'h0, i[2] & (i[1] | i[0])}, {31'h0, share_o});
        end
        apb(1'b0, `MFE_OFF_STATUS, 32'h0, {25'h0, TML});
        stop_test();
    end
endmodule
